// ==== timer_buffer_pair.sv ====
// One buffer register paired with a general register.
// Assumes the counter core reports compare match and capture in the event cycle.
`default_nettype none
module timer_buffer_pair (
  input wire logic core_clk_i, // System clock
  input wire logic nrst_i, // Sync reset, active low
  input wire logic standby_i, // Standby entry
  input wire logic enable_i, // Buffering enabled
  input wire timer_clksel_pkg::gr_event_t ev_i, // General register event
  input wire logic [1:0] wr_byte_i, // CPU write byte strobes
  input wire logic [15:0] wr_data_i, // CPU write data
  output logic [15:0] buf_o, // Buffer contents
  output var timer_clksel_pkg::gr_load_t load_o // Load of general register
);
  logic [15:0] buf_q;
  assign buf_o = buf_q;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || standby_i) begin
      buf_q <= timer_clksel_pkg::BUF_RESET;
    end else if (enable_i && ev_i.is_capture && ev_i.capture) begin
      buf_q <= ev_i.general_reg;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (wr_byte_i[b]) begin
          buf_q[b*8 +: 8] <= wr_data_i[b*8 +: 8];
        end
      end
    end
  end

  // Copy on compare match is registered and pulses in the cycle after the match
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || standby_i) begin
      load_o <= '0;
    end else begin
      load_o.write <= 1'b0;
      load_o.load <= enable_i && !ev_i.is_capture && ev_i.compare_match;
      load_o.value <= buf_q;
    end
  end
endmodule
`default_nettype wire

// ==== timer_clksel.sv ====
// Clock, clear selection and buffer registers for a five-channel 16-bit timer.
// Assumes CPU accesses take one cycle and the counter core supplies events and modes.
`default_nettype none
module timer_clksel (
  input wire logic core_clk_i, // System clock
  input wire logic nrst_i, // Sync reset, active low
  input wire logic standby_i, // Standby entry
  input wire logic [3:0] addr_i, // Register index
  input wire logic rd_i, // Read strobe
  input wire logic [1:0] wr_byte_i, // Write byte strobes
  input wire logic [15:0] wdata_i, // Write data
  input wire logic [3:0] ext_clock_pin_i, // Pins a..d
  input wire logic phase_count_enable_i, // Channel two phase counting
  input wire logic [4:0] sync_select_i, // Synchronised channels
  input wire logic [9:0] io_capture_i, // Capture mode per GR, from io control
  input wire logic [9:0] compare_match_i, // Compare match per GR
  input wire logic [9:0] capture_i, // Input capture per GR
  input wire logic [63:0] ch34_general_reg_i, // GRs ch3 A,B then ch4 A,B
  output logic [15:0] rdata_o, // Read data
  output logic [4:0] count_tick_o, // Counter advance per channel
  output logic [4:0] counter_clear_o, // Counter clear per channel
  output logic [3:0] gr_load_o, // Load GR from buffer
  output logic [63:0] gr_load_value_o // Load values
);
  timer_clksel_pkg::count_control_t ctrl_q [timer_clksel_pkg::NUM_CH];
  logic [3:0] func_q;
  logic [2:0] presc_q;
  logic [3:0] pin_q;
  logic [15:0] buf_w [timer_clksel_pkg::NUM_BUF];
  logic [4:0] tick_d;
  logic [4:0] clear_d;
  logic [4:0] own_clear;
  logic sync_clear;

  function automatic logic is_gr_event(input logic cap, input logic cm, input logic ic);
    is_gr_event = cap ? ic : cm;
  endfunction

  // Control registers, bit seven held at one
  for (genvar c = 0; c < timer_clksel_pkg::NUM_CH; c++) begin : g_ctrl
    always_ff @(posedge core_clk_i) begin
      if (!nrst_i || standby_i) begin
        ctrl_q[c] <= timer_clksel_pkg::CTRL_RESET;
      end else if (wr_byte_i[0] && addr_i == timer_clksel_pkg::ADDR_CTRL0 + 4'(c)) begin
        ctrl_q[c] <= {1'b1, wdata_i[6:0]};
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || standby_i) begin
      func_q <= timer_clksel_pkg::FUNC_RESET;
    end else if (wr_byte_i[0] && addr_i == timer_clksel_pkg::ADDR_FUNC) begin
      func_q <= wdata_i[3:0];
    end
  end

  // Free running prescaler and pin history
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      presc_q <= '0;
      pin_q <= '0;
    end else begin
      presc_q <= presc_q + 3'h1;
      pin_q <= ext_clock_pin_i;
    end
  end

  // Buffers: index 0 ch3 A, 1 ch3 B, 2 ch4 A, 3 ch4 B
  for (genvar b = 0; b < timer_clksel_pkg::NUM_BUF; b++) begin : g_buf
    timer_clksel_pkg::gr_event_t ev;
    timer_clksel_pkg::gr_load_t ld;
    logic [1:0] wb;
    assign ev.is_capture = io_capture_i[6+b];
    assign ev.compare_match = compare_match_i[6+b];
    assign ev.capture = capture_i[6+b];
    assign ev.general_reg = ch34_general_reg_i[b*16 +: 16];
    assign wb = (addr_i == timer_clksel_pkg::ADDR_BUF0 + 4'(b)) ? wr_byte_i : 2'b00;
    timer_buffer_pair u_pair (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .standby_i(standby_i),
      .enable_i(func_q[b]),
      .ev_i(ev),
      .wr_byte_i(wb),
      .wr_data_i(wdata_i),
      .buf_o(buf_w[b]),
      .load_o(ld)
    );
    assign gr_load_o[b] = ld.load;
    assign gr_load_value_o[b*16 +: 16] = ld.value;
  end

  // Count source and clear selection per channel
  always_comb begin
    tick_d = '0;
    own_clear = '0;
    for (int c = 0; c < timer_clksel_pkg::NUM_CH; c++) begin
      logic cur;
      logic prev;
      logic [1:0] pin;
      cur = 1'b0;
      prev = 1'b0;
      pin = ctrl_q[c].source_sel[1:0];
      if (c == 2 && phase_count_enable_i) begin
        tick_d[c] = 1'b0;
      end else if (!ctrl_q[c].source_sel[2]) begin
        unique case (ctrl_q[c].source_sel[1:0])
          2'h0: tick_d[c] = 1'b1;
          2'h1: tick_d[c] = presc_q[0];
          2'h2: tick_d[c] = presc_q[1:0] == 2'h3;
          default: tick_d[c] = presc_q == 3'h7;
        endcase
      end else begin
        cur = ext_clock_pin_i[pin];
        prev = pin_q[pin];
        if (ctrl_q[c].edge_sel[1]) begin
          tick_d[c] = cur != prev;
        end else if (ctrl_q[c].edge_sel == timer_clksel_pkg::EDGE_RISE) begin
          tick_d[c] = cur && !prev;
        end else begin
          tick_d[c] = !cur && prev;
        end
      end
      unique case (ctrl_q[c].clear_sel)
        timer_clksel_pkg::CLR_GRA: own_clear[c] =
          is_gr_event(io_capture_i[2*c], compare_match_i[2*c], capture_i[2*c]);
        timer_clksel_pkg::CLR_GRB: own_clear[c] =
          is_gr_event(io_capture_i[2*c+1], compare_match_i[2*c+1], capture_i[2*c+1]);
        default: own_clear[c] = 1'b0;
      endcase
    end
  end

  always_comb begin
    sync_clear = 1'b0;
    for (int c = 0; c < timer_clksel_pkg::NUM_CH; c++) begin
      if (sync_select_i[c] && ctrl_q[c].clear_sel != timer_clksel_pkg::CLR_SYNC &&
          own_clear[c]) begin
        sync_clear = 1'b1;
      end
    end
    for (int c = 0; c < timer_clksel_pkg::NUM_CH; c++) begin
      clear_d[c] = own_clear[c] ||
        (sync_select_i[c] && ctrl_q[c].clear_sel == timer_clksel_pkg::CLR_SYNC &&
         sync_clear);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || standby_i) begin
      count_tick_o <= '0;
      counter_clear_o <= '0;
    end else begin
      count_tick_o <= tick_d;
      counter_clear_o <= clear_d;
    end
  end

  // Read data registered; unmapped reads return zero
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      if (addr_i <= timer_clksel_pkg::ADDR_CTRL4) begin
        rdata_o <= {8'h00, ctrl_q[addr_i[2:0]]};
      end else if (addr_i >= timer_clksel_pkg::ADDR_BUF0 &&
                   addr_i <= timer_clksel_pkg::ADDR_BUF3) begin
        rdata_o <= buf_w[addr_i[1:0]];
      end else if (addr_i == timer_clksel_pkg::ADDR_FUNC) begin
        rdata_o <= {12'h000, func_q};
      end else begin
        rdata_o <= '0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== timer_clksel_pkg.sv ====
// Package for the timer clock select and buffer block: register map, fields, resets.
// Assumes a 16-bit internal CPU bus with word and byte strobes.
`default_nettype none
package timer_clksel_pkg;
  localparam int NUM_CH = 5;
  localparam int NUM_BUF = 4;
  // Register index on the internal bus
  localparam logic [3:0] ADDR_CTRL0 = 4'h0;
  localparam logic [3:0] ADDR_CTRL4 = 4'h4;
  localparam logic [3:0] ADDR_BUF0 = 4'h8;
  localparam logic [3:0] ADDR_BUF3 = 4'hb;
  localparam logic [3:0] ADDR_FUNC = 4'hc;
  localparam logic [7:0] CTRL_RESET = 8'h80;
  localparam logic [15:0] BUF_RESET = 16'hffff;
  localparam logic [3:0] FUNC_RESET = 4'h0;
  localparam int CTRL_FIXED_BIT = 7;
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_GRA = 2'h1;
  localparam logic [1:0] CLR_GRB = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [2:0] DIV_PRESCALE_W = 3'h3;

  typedef struct packed {
    logic fixed_one;
    logic [1:0] clear_sel;
    logic [1:0] edge_sel;
    logic [2:0] source_sel;
  } count_control_t;

  // Per general register event from the counter core
  typedef struct packed {
    logic is_capture;
    logic compare_match;
    logic capture;
    logic [15:0] general_reg;
  } gr_event_t;

  typedef struct packed {
    logic write;
    logic load;
    logic [15:0] value;
  } gr_load_t;
endpackage
`default_nettype wire

// ==== timer_clksel_props.sv ====
// Port-level checker for the timer clock select and buffer block.
// Assumes registered one-cycle outputs and reads answered one cycle after the strobe.
`default_nettype none
module timer_clksel_props (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic standby_i,
  input wire logic [3:0] addr_i,
  input wire logic rd_i,
  input wire logic phase_count_enable_i,
  input wire logic [4:0] sync_select_i,
  input wire logic [9:0] io_capture_i,
  input wire logic [9:0] compare_match_i,
  input wire logic [9:0] capture_i,
  input wire logic [15:0] rdata_o,
  input wire logic [4:0] count_tick_o,
  input wire logic [4:0] counter_clear_o,
  input wire logic [3:0] gr_load_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_load_a3; gr_load_o[0] |-> $past(compare_match_i[6] && !io_capture_i[6]); endproperty
  a_load_a3: assert property (p_load_a3) else $error("load without compare");
  property p_load_b4; gr_load_o[3] |-> $past(compare_match_i[9] && !io_capture_i[9]); endproperty
  a_load_b4: assert property (p_load_b4) else $error("load without compare");
  property p_cap_noload; $past(capture_i[6] && io_capture_i[6] && !compare_match_i[6]) |-> !gr_load_o[0];
  endproperty
  a_cap_noload: assert property (p_cap_noload) else $error("load on capture");
  property p_clr0; counter_clear_o[0] && !$past(sync_select_i[0]) |->
    $past(|((compare_match_i[1:0] & ~io_capture_i[1:0]) | (capture_i[1:0] & io_capture_i[1:0])));
  endproperty
  a_clr0: assert property (p_clr0) else $error("clear without event");
  property p_phase; $past(phase_count_enable_i) |-> !count_tick_o[2]; endproperty
  a_phase: assert property (p_phase) else $error("tick in phase mode");
  property p_rd_hold; $past(nrst_i) && !$past(rd_i) && !$past(standby_i) |-> $stable(rdata_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_bit7; $past(rd_i && addr_i < 4'h5 && nrst_i && !standby_i) |-> rdata_o[7]; endproperty
  a_bit7: assert property (p_bit7) else $error("fixed bit low");
  property p_unmapped;
    $past(rd_i && addr_i inside {[4'h5:4'h7], [4'hd:4'hf]} && nrst_i) |-> rdata_o == 16'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  c_load: cover property (gr_load_o[0]);
  c_clr: cover property (counter_clear_o[0]);
  c_tick: cover property (count_tick_o[1]);
endmodule
`default_nettype wire

// ==== timer_clksel_tb.sv ====
// Self-checking bench for the timer clock select and buffer block.
// Assumes strobes are taken at an edge and read data lands one cycle later.
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module timer_clksel_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0, nrst_i = 1'b0, standby_i = 1'b0, rd_i = 1'b0, ph = 1'b0, run = 1'b0;
  logic [3:0] addr_i = 4'h0, pins, ld;
  logic [1:0] wr_byte_i = 2'h0;
  logic [15:0] wdata_i = 16'h0, rdata_o;
  logic [9:0] io_cap = 10'h0, cmp = 10'h0, cap = 10'h0;
  logic [63:0] gr = 64'h0, ldv;
  logic [4:0] tick, clr;
  logic [4:0] sync = 5'h0;
  int err_total = 0, n_checks = 0, cyc = 0, k, j;
  timer_pin_model u_pins (.clk_i(core_clk_i), .run_i(run), .pins_o(pins));
  timer_clksel dut (.core_clk_i, .nrst_i, .standby_i, .addr_i, .rd_i, .wr_byte_i, .wdata_i,
    .ext_clock_pin_i(pins), .phase_count_enable_i(ph), .sync_select_i(sync),
    .io_capture_i(io_cap), .compare_match_i(cmp), .capture_i(cap), .ch34_general_reg_i(gr),
    .rdata_o, .count_tick_o(tick), .counter_clear_o(clr), .gr_load_o(ld), .gr_load_value_o(ldv));
  always #4 core_clk_i = ~core_clk_i;
  // Whole run needs about 370 cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  task print_verdict;
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] b);
    @(posedge core_clk_i); #1; addr_i = a; wdata_i = d; wr_byte_i = b;
    @(posedge core_clk_i); #1; wr_byte_i = 2'h0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk_i); #1; addr_i = a; rd_i = 1'b1;
    @(posedge core_clk_i); #1; rd_i = 1'b0;
    `CHK(rdata_o, e)
  endtask
  task ev(input logic [9:0] m, input logic [9:0] c);
    @(posedge core_clk_i); #1; cmp = m; cap = c;
    @(posedge core_clk_i); #1; cmp = 10'h0; cap = 10'h0;
  endtask
  task cnt(input int c, input int n, output int t);
    t = 0;
    repeat (n) begin @(posedge core_clk_i); #1; t += int'(tick[c] === 1'b1); end
  endtask
  task t_reset;
    for (int i = 0; i < 16; i++)
      rd(4'(i), i < 5 ? 16'h0080 : (i > 7 && i < 12) ? 16'hffff : 16'h0);
    `CHK(tick, 5'h1f)
    `CHK(clr, 5'h00)
  endtask
  task t_regs;
    wr(4'h0, 16'h007f, 2'h3); rd(4'h0, 16'h00ff);
    wr(4'h9, 16'h1234, 2'h1); rd(4'h9, 16'hff34);
    wr(4'h9, 16'h5678, 2'h2); rd(4'h9, 16'h5634);
  endtask
  task t_buffer;
    wr(4'hc, 16'h0003, 2'h1); wr(4'h8, 16'habcd, 2'h3); ev(10'h040, 10'h0);
    `CHK(ld, 4'h1)
    `CHK(ldv[15:0], 16'habcd)
    wr(4'hc, 16'h0002, 2'h1); ev(10'h040, 10'h0); `CHK(ld, 4'h0)
    io_cap = 10'h0c0; gr[31:0] = 32'h5555_1111; ev(10'h0, 10'h0c0);
    `CHK(ld, 4'h0)
    rd(4'h9, 16'h5555);
    rd(4'h8, 16'habcd);
    wr(4'hc, 16'h0008, 2'h1); ev(10'h200, 10'h0);
    `CHK(ld, 4'h8)
    `CHK(ldv[63:48], 16'hffff)
  endtask
  task t_clear;
    wr(4'h0, 16'h0020, 2'h1); ev(10'h001, 10'h0); `CHK(clr[0], 1'b1)
    ev(10'h002, 10'h0); `CHK(clr[0], 1'b0)
    sync = 5'h03; wr(4'h1, 16'h0060, 2'h1); ev(10'h001, 10'h0);
    `CHK(clr[1:0], 2'h3)
    sync = 5'h02; ev(10'h001, 10'h0);
    `CHK(clr[1:0], 2'h1)
    sync = 5'h00;
  endtask
  task t_source;
    for (int s = 0; s < 4; s++) begin
      wr(4'h1, 16'(s), 2'h1); cnt(1, 16, k); `CHK(k, 16 >> s)
    end
    for (int e = 0; e < 4; e++) begin
      wr(4'h1, 16'h0004 | 16'(e << 3) | 16'(e), 2'h1); run = 1'b1; cnt(1, 32, k);
      run = 1'b0; cnt(1, 8, j); `CHK(k + j, e >= 2 ? 8 : 4)
    end
    ph = 1'b1; wr(4'h2, 16'h0, 2'h1); cnt(2, 16, k); `CHK(k, 0)
    ph = 1'b0; cnt(2, 16, k); `CHK(k, 16)
  endtask
  task t_standby;
    @(posedge core_clk_i); #1; standby_i = 1'b1;
    @(posedge core_clk_i); #1; standby_i = 1'b0;
    rd(4'h9, 16'hffff); rd(4'h1, 16'h0080);
    rd(4'hc, 16'h0000);
  endtask
  initial begin
    repeat (12) @(posedge core_clk_i);
    #1; nrst_i = 1'b1;
    t_reset(); t_regs(); t_buffer(); t_clear(); t_source(); t_standby();
    print_verdict();
  end
endmodule
bind timer_clksel timer_clksel_props u_props (.core_clk_i, .nrst_i, .standby_i, .addr_i, .rd_i,
  .phase_count_enable_i, .sync_select_i, .io_capture_i, .compare_match_i, .capture_i, .rdata_o,
  .count_tick_o, .counter_clear_o, .gr_load_o);
`default_nettype wire

// ==== timer_pin_model.sv ====
// Far-side model of the external clock pins.
// Assumes the bench raises run_i for whole bursts; pins rest low between bursts.
`default_nettype none
module timer_pin_model (
  input wire logic clk_i, // System clock
  input wire logic run_i, // Burst enable
  output logic [3:0] pins_o // Pins a..d
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_q = 2'h0;
  initial pins_o = 4'h0;
  // All pins toggle every four cycles, so a burst of 32 cycles ends low again
  always @(posedge clk_i) begin
    div_q <= run_i ? div_q + 2'h1 : 2'h0;
    if (run_i && div_q == 2'h3) pins_o <= ~pins_o;
  end
endmodule
`default_nettype wire
